// ==== design/lmc_pkg.sv ====
package lmc_pkg;
  // gray along idle, wake, integrate, convert
  typedef enum logic [1:0] {
    LMC_ST_IDLE = 2'h0,
    LMC_ST_WAKE = 2'h1,
    LMC_ST_INTEG = 2'h3,
    LMC_ST_ADC = 2'h2
  } lmc_state_t;
  typedef enum logic [1:0] {
    LMC_MODE_OFF = 2'h0,
    LMC_MODE_FORCED = 2'h1,
    LMC_MODE_REGULAR = 2'h2,
    LMC_MODE_CONT = 2'h3
  } lmc_mode_t;
endpackage : lmc_pkg

// ==== design/lmc_regs.svh ====
`ifndef LMC_REGS_SVH
`define LMC_REGS_SVH
// ***************************************
// register map
// ***************************************
`define LMC_ADDR_CONFIG 8'h00
`define LMC_ADDR_RESULT 8'h04
`define LMC_ADDR_STATUS 8'h08
`define LMC_CFG_RANGE 3:0
`define LMC_CFG_CONV 7:4
`define LMC_CFG_MODE 9:8
`define LMC_RES_EXP 31:28
`define LMC_RES_MANT 27:8
`define LMC_RES_COUNT 7:4
`define LMC_STA_BUSY 0
`define LMC_STA_STATE 2:1
`define LMC_STA_MODE 5:4
// ***************************************
// reset values and codes
// ***************************************
`define LMC_RANGE_AUTO 4'hc
`define LMC_RANGE_MAX 4'h8
`define LMC_CONV_LONGEST 4'hb
`define LMC_CONV_RESET 4'hb
`define LMC_COUNT_RESET 4'h0
// ***************************************
// timing
// ***************************************
`define LMC_CLK_PERIOD_NS 4
`define LMC_WAKE_MS 0.5
`define LMC_ADC_US 100
`define LMC_CONV_MIN_US 600
`define LMC_CONV_MAX_MS 800
`endif

// ==== design/lmc_top.sv ====
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "lmc_regs.svh"
module lmc_top
  import lmc_pkg::*;
#(
  parameter int unsigned CYC_PER_US = 1000 / `LMC_CLK_PERIOD_NS,
  parameter int unsigned WAKE_CYC = int'(`LMC_WAKE_MS * 1000.0 * CYC_PER_US),
  parameter int unsigned ADC_CYC = `LMC_ADC_US * CYC_PER_US,
  parameter int unsigned CONV_US [12] = '{`LMC_CONV_MIN_US, 1000, 2000, 4000, 8000, 16000,
    32000, 64000, 128000, 256000, 512000, `LMC_CONV_MAX_MS * 1000}
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [19:0] AFE_MANT,
  input wire logic [3:0] AFE_EXP,
  output logic [3:0] AFE_RANGE,
  output logic AFE_AR_CLEAR,
  output logic AFE_INTEG,
  output logic AFE_CONVERT,
  output logic RESULT_EVT
);

  // ***************************************
  // decode helpers
  // ***************************************
  // undefined period codes fall back to the longest period
  function automatic logic [31:0] conv_cyc(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `LMC_CONV_LONGEST) ? `LMC_CONV_LONGEST : code;
    conv_cyc = 32'(CONV_US[c] * CYC_PER_US);
  endfunction : conv_cyc

  // out-of-table fixed codes clamp to the widest range
  function automatic logic [3:0] eff_range(input logic [3:0] code);
    if (code == `LMC_RANGE_AUTO)
      eff_range = `LMC_RANGE_AUTO;
    else if (code > `LMC_RANGE_MAX)
      eff_range = `LMC_RANGE_MAX;
    else
      eff_range = code;
  endfunction : eff_range

  // ***************************************
  // state
  // ***************************************
  lmc_state_t state_reg, state_next;
  lmc_mode_t mode_reg, mode_next;
  logic [3:0] cfg_range_reg, cfg_range_next;
  logic [3:0] cfg_conv_reg, cfg_conv_next;
  logic [3:0] run_range_reg, run_range_next;
  logic [3:0] run_conv_reg, run_conv_next;
  logic [31:0] timer_reg, timer_next;
  logic [31:0] result_reg, result_next;
  logic [3:0] count_reg, count_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [3:0] afe_range_reg;
  logic ar_clear_reg, integ_reg, convert_reg, evt_reg;

  // ***************************************
  // register write decode
  // ***************************************
  wire cfg_wr = WR && (ADDR == `LMC_ADDR_CONFIG);
  wire [1:0] wr_mode = WDATA[`LMC_CFG_MODE];
  wire wr_oneshot = (wr_mode == LMC_MODE_FORCED) || (wr_mode == LMC_MODE_REGULAR);
  wire idle = (state_reg == LMC_ST_IDLE);
  // a one-shot request is only taken while idle; stop or continuous always lands
  wire mode_take = cfg_wr && (idle || !wr_oneshot);

  // ***************************************
  // sequencing
  // ***************************************
  wire tdone = (timer_reg == 32'h0);
  wire start = idle && (mode_reg != LMC_MODE_OFF);
  wire adc_end = (state_reg == LMC_ST_ADC) && tdone;
  wire cont = (mode_reg == LMC_MODE_CONT);
  wire enter_integ = ((state_reg == LMC_ST_WAKE) && tdone) || (adc_end && cont);
  wire [31:0] integ_cyc = conv_cyc(cfg_conv_reg) - 32'(ADC_CYC);

  // next state of the measurement sequencer
  always_comb
  begin
    case (state_reg)
      LMC_ST_IDLE: state_next = start ? LMC_ST_WAKE : LMC_ST_IDLE;
      LMC_ST_WAKE: state_next = tdone ? LMC_ST_INTEG : LMC_ST_WAKE;
      LMC_ST_INTEG: state_next = tdone ? LMC_ST_ADC : LMC_ST_INTEG;
      LMC_ST_ADC: state_next = tdone ? (cont ? LMC_ST_INTEG : LMC_ST_IDLE) : LMC_ST_ADC;
      default: state_next = LMC_ST_IDLE;
    endcase
  end

  // one down-timer serves all phases; it reloads on every phase entry
  always_comb
  begin
    if (start)
      timer_next = 32'(WAKE_CYC) - 32'h1;
    else if (enter_integ)
      timer_next = integ_cyc - 32'h1;
    else if ((state_reg == LMC_ST_INTEG) && tdone)
      timer_next = 32'(ADC_CYC) - 32'h1;
    else if (tdone)
      timer_next = 32'h0;
    else
      timer_next = timer_reg - 32'h1;
  end

  // a stop or continuous write wins over the end-of-shot clear
  assign mode_next = mode_take ? lmc_mode_t'(wr_mode) :
                     (adc_end && !cont) ? LMC_MODE_OFF : mode_reg;
  assign cfg_range_next = cfg_wr ? WDATA[`LMC_CFG_RANGE] : cfg_range_reg;
  assign cfg_conv_next = cfg_wr ? WDATA[`LMC_CFG_CONV] : cfg_conv_reg;
  // settings are frozen per measurement so a mid-run write cannot tear it
  assign run_range_next = enter_integ ? eff_range(cfg_range_reg) : run_range_reg;
  assign run_conv_next = enter_integ ? cfg_conv_reg : run_conv_reg;

  // ***************************************
  // result capture
  // ***************************************
  wire [3:0] res_exp = (run_range_reg == `LMC_RANGE_AUTO) ? AFE_EXP : run_range_reg;
  assign count_next = adc_end ? count_reg + 4'h1 : count_reg;
  // counter and result written on the same edge
  always_comb
  begin
    result_next = result_reg;
    if (adc_end)
    begin
      result_next = 32'h0;
      result_next[`LMC_RES_EXP] = res_exp;
      result_next[`LMC_RES_MANT] = AFE_MANT;
      result_next[`LMC_RES_COUNT] = count_next;
    end
  end

  // ***************************************
  // register read
  // ***************************************
  wire [31:0] cfg_view = {22'h0, mode_reg, cfg_conv_reg, cfg_range_reg};
  wire [31:0] sta_view = {26'h0, mode_reg, 1'b0, state_reg, !idle};
  wire [31:0] rd_mux = (ADDR == `LMC_ADDR_CONFIG) ? cfg_view :
                       (ADDR == `LMC_ADDR_RESULT) ? result_reg :
                       (ADDR == `LMC_ADDR_STATUS) ? sta_view : 32'h0;
  // data stand for one cycle only, zero otherwise
  assign rdata_next = RD ? rd_mux : 32'h0;

  // ***************************************
  // flops
  // ***************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= LMC_ST_IDLE;
      mode_reg <= LMC_MODE_OFF;
      cfg_range_reg <= `LMC_RANGE_AUTO;
      cfg_conv_reg <= `LMC_CONV_RESET;
      run_range_reg <= `LMC_RANGE_AUTO;
      run_conv_reg <= `LMC_CONV_RESET;
      timer_reg <= 32'h0;
      result_reg <= 32'h0;
      count_reg <= `LMC_COUNT_RESET;
      rdata_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cfg_range_reg <= cfg_range_next;
      cfg_conv_reg <= cfg_conv_next;
      run_range_reg <= run_range_next;
      run_conv_reg <= run_conv_next;
      timer_reg <= timer_next;
      result_reg <= result_next;
      count_reg <= count_next;
      rdata_reg <= rdata_next;
    end
  end

  // front-end control and event outputs, all registered
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      afe_range_reg <= `LMC_RANGE_AUTO;
      ar_clear_reg <= 1'b0;
      integ_reg <= 1'b0;
      convert_reg <= 1'b0;
      evt_reg <= 1'b0;
    end
    else
    begin
      afe_range_reg <= run_range_next;
      ar_clear_reg <= start && (mode_reg == LMC_MODE_FORCED);
      integ_reg <= (state_next == LMC_ST_INTEG);
      convert_reg <= (state_next == LMC_ST_ADC);
      evt_reg <= adc_end;
    end
  end

  assign RDATA = rdata_reg;
  assign AFE_RANGE = afe_range_reg;
  assign AFE_AR_CLEAR = ar_clear_reg;
  assign AFE_INTEG = integ_reg;
  assign AFE_CONVERT = convert_reg;
  assign RESULT_EVT = evt_reg;

  // ***************************************
  // checks
  // ***************************************
  logic [31:0] wake_cnt_reg, busy_cnt_reg;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wake_cnt_reg <= 32'h0;
      busy_cnt_reg <= 32'h0;
    end
    else
    begin
      wake_cnt_reg <= start ? 32'h0 : wake_cnt_reg + 32'h1;
      busy_cnt_reg <= enter_integ ? 32'h0 : busy_cnt_reg + 32'h1;
    end
  end

  sequence s_trigger;
    idle && (mode_reg != LMC_MODE_OFF);
  endsequence
  sequence s_wake_exit;
    (state_reg == LMC_ST_WAKE) && (state_next == LMC_ST_INTEG);
  endsequence

  chk_reset_auto_range: assert property (@(posedge CLK) RST |=> cfg_range_reg == `LMC_RANGE_AUTO)
    else $error("range not automatic after reset");
  chk_reset_shutdown: assert property (@(posedge CLK) RST |=> idle && !AFE_INTEG && !AFE_CONVERT)
    else $error("not in shutdown after reset");
  chk_trigger_wakes: assert property (@(posedge CLK) disable iff (RST)
    s_trigger |=> (state_reg == LMC_ST_WAKE) ##1 (AFE_INTEG == 1'b0))
    else $error("trigger did not enter wake phase");
  chk_wake_length: assert property (@(posedge CLK) disable iff (RST)
    s_wake_exit |-> wake_cnt_reg == WAKE_CYC - 1)
    else $error("wake delay length wrong");
  chk_conv_length: assert property (@(posedge CLK) disable iff (RST)
    adc_end |-> busy_cnt_reg == conv_cyc(run_conv_reg) - 32'h1)
    else $error("conversion length wrong");
  chk_longest_period: assert property (@(posedge CLK) disable iff (RST)
    adc_end && (run_conv_reg == `LMC_CONV_LONGEST) |->
      busy_cnt_reg == 32'(CONV_US[`LMC_CONV_LONGEST] * CYC_PER_US) - 32'h1)
    else $error("longest period wrong");
  chk_adc_after_integ: assert property (@(posedge CLK) disable iff (RST)
    $rose(AFE_CONVERT) |-> $past(AFE_INTEG) && !AFE_INTEG)
    else $error("adc interval not after integration");
  chk_count_wrap: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT |-> count_reg == 4'($past(count_reg) + 4'h1))
    else $error("counter step wrong");
  chk_count_pairs: assert property (@(posedge CLK) disable iff (RST)
    $changed(count_reg) |-> RESULT_EVT && (result_reg[`LMC_RES_COUNT] == count_reg)
      && $changed(result_reg))
    else $error("counter and result out of step");
  chk_result_exp: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT |-> result_reg[`LMC_RES_EXP] ==
      (($past(run_range_reg) == `LMC_RANGE_AUTO) ? $past(AFE_EXP) : $past(run_range_reg)))
    else $error("exponent wrong");
  chk_result_mant: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT |-> result_reg[`LMC_RES_MANT] == $past(AFE_MANT))
    else $error("mantissa wrong");
  chk_shot_clears: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT && ($past(mode_reg) != LMC_MODE_CONT) && !$past(cfg_wr) |-> mode_reg == LMC_MODE_OFF)
    else $error("one-shot mode not cleared");
  chk_busy_ignore: assert property (@(posedge CLK) disable iff (RST)
    !idle && cfg_wr && wr_oneshot && !adc_end |=> mode_reg == $past(mode_reg))
    else $error("trigger taken while busy");
  chk_forced_clear: assert property (@(posedge CLK) disable iff (RST)
    s_trigger and (mode_reg == LMC_MODE_FORCED) |=> AFE_AR_CLEAR ##1 !AFE_AR_CLEAR)
    else $error("forced auto-range clear missing");

  // ***************************************
  // checks on outputs and sequencing
  // ***************************************
  // one-shot end with no software write beside it
  sequence s_shot_end;
    adc_end && !cont && !cfg_wr;
  endsequence
  // last adc cycle, then the event as the adc interval closes
  sequence s_result_out;
    AFE_CONVERT ##1 (RESULT_EVT && !AFE_CONVERT);
  endsequence

  // reset values of the counter and the period
  chk_count_reset: assert property (@(posedge CLK) RST |=> count_reg == `LMC_COUNT_RESET)
    else $error("counter not cleared by reset");
  chk_period_reset: assert property (@(posedge CLK) RST |=> cfg_conv_reg == `LMC_CONV_RESET)
    else $error("period not longest after reset");
  // counter moves only with a finished measurement
  chk_count_hold: assert property (@(posedge CLK) disable iff (RST)
    !adc_end |=> count_reg == $past(count_reg))
    else $error("counter moved without a result");
  // read data stand one cycle, zero otherwise
  chk_result_read: assert property (@(posedge CLK) disable iff (RST)
    RD && (ADDR == `LMC_ADDR_RESULT) |=> RDATA == $past(result_reg))
    else $error("result read wrong");
  chk_read_idle: assert property (@(posedge CLK) disable iff (RST)
    !RD |=> RDATA == 32'h0)
    else $error("read data without a read");
  // range handed to the front end at integration start
  chk_auto_range_out: assert property (@(posedge CLK) disable iff (RST)
    enter_integ && (cfg_range_reg == `LMC_RANGE_AUTO) |=> AFE_RANGE == `LMC_RANGE_AUTO)
    else $error("automatic range not passed on");
  chk_fixed_range_out: assert property (@(posedge CLK) disable iff (RST)
    enter_integ && (cfg_range_reg != `LMC_RANGE_AUTO) |=> AFE_RANGE <= `LMC_RANGE_MAX)
    else $error("fixed range outside the nine");
  chk_manual_exp: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT && ($past(run_range_reg) != `LMC_RANGE_AUTO) |-> result_reg[`LMC_RES_EXP] <= `LMC_RANGE_MAX)
    else $error("manual exponent outside the nine");
  // result line pulses once per measurement
  chk_event_pulse: assert property (@(posedge CLK) disable iff (RST)
    RESULT_EVT |=> !RESULT_EVT)
    else $error("result event longer than a cycle");
  chk_result_event: assert property (@(posedge CLK) disable iff (RST)
    adc_end |-> s_result_out)
    else $error("result event not after adc interval");
  // no front-end activity in shutdown
  chk_shutdown_quiet: assert property (@(posedge CLK) disable iff (RST)
    idle && (mode_reg == LMC_MODE_OFF) |=> !AFE_INTEG && !AFE_CONVERT)
    else $error("front end active in shutdown");
  // continuous goes straight back to integration, no wake
  chk_cont_no_wake: assert property (@(posedge CLK) disable iff (RST)
    adc_end && cont |=> AFE_INTEG)
    else $error("continuous run did not re-integrate");
  chk_shot_idle: assert property (@(posedge CLK) disable iff (RST)
    s_shot_end |=> idle && (mode_reg == LMC_MODE_OFF))
    else $error("one-shot did not return to shutdown");
  // mode codes land as written when taken
  chk_mode_taken: assert property (@(posedge CLK) disable iff (RST)
    mode_take |=> mode_reg == $past(wr_mode))
    else $error("mode code not stored");
  chk_regular_no_clear: assert property (@(posedge CLK) disable iff (RST)
    s_trigger and (mode_reg != LMC_MODE_FORCED) |=> !AFE_AR_CLEAR)
    else $error("auto-range clear outside forced mode");
  // a stop lets the running measurement finish
  chk_stop_finishes: assert property (@(posedge CLK) disable iff (RST)
    cfg_wr && (wr_mode == LMC_MODE_OFF) && (state_reg == LMC_ST_INTEG) |=> !idle)
    else $error("stop cut a measurement short");

endmodule : lmc_top
`default_nettype wire

// ==== testbench/lmc_afe_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// front-end stand-in
// ****************************************
module lmc_afe_model (
  input wire logic clk,
  input wire logic convert,
  input wire logic [19:0] mant_src,
  input wire logic [3:0] exp_src,
  output logic [19:0] mant,
  output logic [3:0] expo
);
  logic flip = 1'b0;
  // toggles every cycle so a sample taken outside conversion shows
  always @(posedge clk)
    flip <= ~flip;
  // values hold only while the conversion interval runs
  assign mant = convert ? mant_src : {20{flip}};
  assign expo = convert ? exp_src : {4{flip}};
endmodule : lmc_afe_model
`default_nettype wire

// ==== testbench/lmc_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lmc_regs.svh"
module lmc_top_tb import lmc_pkg::*;;
  localparam int WAKE = 50;
  localparam int ADC = 100;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] RDATA, d;
  logic [19:0] AFE_MANT, mant_src = 20'h5a5c3;
  logic [3:0] AFE_EXP, AFE_RANGE, exp_src = 4'h7;
  logic AFE_AR_CLEAR, AFE_INTEG, AFE_CONVERT, RESULT_EVT;
  int bad_count = 0, n_checks = 0, evt_n = 0, clr_n = 0;
  int wake_len = 0, integ_len = 0, conv_len = 0, wc = 0, ic = 0, cc = 0;
  // short periods keep the run small; codes 0..11 give 200..310 cycles
  lmc_top #(.CYC_PER_US(1), .WAKE_CYC(WAKE), .ADC_CYC(ADC),
    .CONV_US('{200, 210, 220, 230, 240, 250, 260, 270, 280, 290, 300, 310})) dut (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .AFE_MANT(AFE_MANT), .AFE_EXP(AFE_EXP), .AFE_RANGE(AFE_RANGE), .AFE_AR_CLEAR(AFE_AR_CLEAR),
    .AFE_INTEG(AFE_INTEG), .AFE_CONVERT(AFE_CONVERT), .RESULT_EVT(RESULT_EVT));
  lmc_afe_model afe (.clk(CLK), .convert(AFE_CONVERT), .mant_src(mant_src), .exp_src(exp_src),
    .mant(AFE_MANT), .expo(AFE_EXP));
  initial
  begin
    forever #2 CLK = ~CLK;
  end
  // phase lengths seen at the pins, kept apart from the core's counters
  always @(posedge CLK)
  begin
    wake_len = (AFE_INTEG === 1'b1 && wc > 0) ? wc : wake_len;
    wc = (AFE_AR_CLEAR === 1'b1) ? 1 : (wc > 0 && AFE_INTEG !== 1'b1) ? wc + 1 : 0;
    integ_len = (AFE_INTEG !== 1'b1 && ic > 0) ? ic : integ_len;
    ic = (AFE_INTEG === 1'b1) ? ic + 1 : 0;
    conv_len = (AFE_CONVERT !== 1'b1 && cc > 0) ? cc : conv_len;
    cc = (AFE_CONVERT === 1'b1) ? cc + 1 : 0;
    evt_n += (RESULT_EVT === 1'b1);
    clr_n += (AFE_AR_CLEAR === 1'b1);
  end
  function automatic logic [31:0] cfg(input logic [3:0] r, input logic [3:0] p, input lmc_mode_t m);
    return {22'h0, m, p, r};
  endfunction : cfg
  function automatic logic [31:0] res(input logic [3:0] e, input logic [3:0] c);
    return {e, mant_src, c, 4'h0};
  endfunction : res
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, want);
    end
  endtask : chk_val
  task automatic chk_len(input int got, input int want);
    n_checks++;
    if (got != want)
    begin
      bad_count++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, want);
    end
  endtask : chk_len
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk_val(RDATA, want);
  endtask : rd_chk
  task automatic wait_evt;
    for (int i = 0; i < 600; i++)
    begin
      @(posedge CLK);
      #1;
      if (RESULT_EVT === 1'b1)
        break;
    end
    chk_val({31'h0, RESULT_EVT}, 32'h1);
  endtask : wait_evt
  initial
  begin
    #60000;
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    rd_chk(`LMC_ADDR_CONFIG, cfg(4'hc, 4'hb, LMC_MODE_OFF));
    rd_chk(`LMC_ADDR_RESULT, 32'h0);
    rd_chk(`LMC_ADDR_STATUS, 32'h0);
    rd_chk(8'h0c, 32'h0);
    chk_val({28'h0, AFE_RANGE}, 32'hc);
    repeat (100) @(posedge CLK);
    chk_len(evt_n, 0);
    // forced one-shot from shutdown at the longest period code
    wr(`LMC_ADDR_CONFIG, cfg(4'hc, 4'hb, LMC_MODE_FORCED));
    wait_evt();
    rd_chk(`LMC_ADDR_RESULT, res(4'h7, 4'h1));
    chk_len(wake_len, WAKE);
    chk_len(integ_len, 310 - ADC);
    chk_len(conv_len, ADC);
    rd_chk(`LMC_ADDR_STATUS, 32'h0);
    // manual range, regular one-shot, retrigger while busy
    wr(`LMC_ADDR_CONFIG, cfg(4'h5, 4'h0, LMC_MODE_REGULAR));
    repeat (WAKE + 6) @(posedge CLK);
    #1;
    chk_val({27'h0, AFE_INTEG, AFE_RANGE}, 32'h15);
    wr(`LMC_ADDR_CONFIG, cfg(4'h5, 4'h0, LMC_MODE_FORCED));
    rd_chk(`LMC_ADDR_STATUS, {26'h0, 2'h2, 1'b0, 2'h3, 1'b1});
    wait_evt();
    rd_chk(`LMC_ADDR_RESULT, res(4'h5, 4'h2));
    chk_len(integ_len, 200 - ADC);
    repeat (700) @(posedge CLK);
    chk_len(evt_n, 2);
    chk_len(clr_n, 1);
    rd_chk(`LMC_ADDR_STATUS, 32'h0);
    // continuous run across the counter wrap
    wr(`LMC_ADDR_CONFIG, cfg(4'hc, 4'h1, LMC_MODE_CONT));
    for (int i = 0; i < 15; i++)
    begin
      wait_evt();
      rd_chk(`LMC_ADDR_RESULT, res(4'h7, 4'(3 + i)));
      chk_len(integ_len, 210 - ADC);
    end
    // stopping lets the running measurement finish first
    wr(`LMC_ADDR_CONFIG, cfg(4'hc, 4'h1, LMC_MODE_OFF));
    wait_evt();
    repeat (500) @(posedge CLK);
    chk_len(evt_n, 18);
    rd_chk(`LMC_ADDR_STATUS, 32'h0);
    // out-of-table codes clamp to the widest range and the longest period
    wr(`LMC_ADDR_CONFIG, cfg(4'hf, 4'hf, LMC_MODE_REGULAR));
    wait_evt();
    rd_chk(`LMC_ADDR_RESULT, res(4'h8, 4'h3));
    chk_len(integ_len, 310 - ADC);
    // reset lands in the middle of a continuous integration
    wr(`LMC_ADDR_CONFIG, cfg(4'hc, 4'h1, LMC_MODE_CONT));
    repeat (WAKE + 20) @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd_chk(`LMC_ADDR_RESULT, 32'h0);
    rd_chk(`LMC_ADDR_CONFIG, cfg(4'hc, 4'hb, LMC_MODE_OFF));
    chk_val({30'h0, AFE_INTEG, AFE_CONVERT}, 32'h0);
    repeat (100) @(posedge CLK);
    chk_len(evt_n, 19);
    conclude();
  end
endmodule : lmc_top_tb
`default_nettype wire
